// ==== hc_consts.svh ====
`ifndef HC_CONSTS_SVH
`define HC_CONSTS_SVH

// own command/status register map (byte addresses)
`define HC_REG_CMD        8'h00
`define HC_REG_CFG        8'h04
`define HC_REG_STATUS     8'h08
`define HC_REG_SETUP_LO   8'h0C
`define HC_REG_SETUP_HI   8'h10
`define HC_REG_TXDATA     8'h14
`define HC_REG_RXDATA     8'h18

// device register map (byte addresses on the device port)
`define HC_DEV_POWER      32'h0000_0000
`define HC_DEV_CSR0       32'h0000_0004
`define HC_DEV_NAKLIMIT0  32'h0000_0008
`define HC_DEV_FIFO0      32'h0000_0020

// power/control bits
`define HC_PWR_PD_EN      0
`define HC_PWR_SUSPEND    1
`define HC_PWR_RESUME     2
`define HC_PWR_RESET      3
`define HC_PWR_HS_ACTIVE  4
`define HC_PWR_HS_EN      5

// endpoint 0 control/status bits
`define HC_CSR_RXRDY      0
`define HC_CSR_TXRDY      1
`define HC_CSR_STALL      2
`define HC_CSR_SETUP      3
`define HC_CSR_ERROR      4
`define HC_CSR_INREQ      5
`define HC_CSR_STATUS     6
`define HC_CSR_NAKTO      7
`define HC_CSR_FLUSH      8

// config register fields
`define HC_CFG_PD_EN      0
`define HC_CFG_HS_EN      1
`define HC_CFG_ABORT      2
`define HC_CFG_LIM_LO     8
`define HC_CFG_LIM_HI     15

// status register fields
`define HC_ST_BUSY        0
`define HC_ST_STALL       1
`define HC_ST_ERROR       2
`define HC_ST_NAKTO       3
`define HC_ST_HS          4
`define HC_ST_SUSP        5
`define HC_ST_DONE        6

// timing
`define HC_HOLD_NS        20000000
`define HC_CLK_NS         20

`define HC_RESP_OKAY      2'b00
`define HC_RESP_SLVERR    2'b10

`endif

// ==== hc_pkg.sv ====
package hc_pkg;

  typedef enum logic [3:0] {
    HC_OP_NONE,
    HC_OP_SUSPEND,
    HC_OP_RESUME,
    HC_OP_BUS_RESET,
    HC_OP_SETUP,
    HC_OP_IN_DATA,
    HC_OP_OUT_DATA,
    HC_OP_IN_STATUS,
    HC_OP_OUT_STATUS,
    HC_OP_NAK_LIMIT
  } hc_op_e;

  typedef enum {
    SQ_IDLE,
    SQ_PWR_SET,
    SQ_HOLD,
    SQ_PWR_CLR,
    SQ_PWR_READ,
    SQ_FIFO_A,
    SQ_FIFO_B,
    SQ_CSR_GO,
    SQ_POLL,
    SQ_RXREAD,
    SQ_RXCLR,
    SQ_NAKFIX,
    SQ_NAKCLR,
    SQ_LIMIT
  } hc_seq_e;

endpackage

// ==== hc_usb_host.sv ====
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`include "hc_consts.svh"

module hc_usb_host
  import hc_pkg::*;
#(
  parameter int HOLD_CYCLES = `HC_HOLD_NS / `HC_CLK_NS
) (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // software side, AXI4-Lite slave
  input  wire logic        s_awvalid_i,
  output logic             s_awready_o,
  input  wire logic [7:0]  s_awaddr_i,
  input  wire logic        s_wvalid_i,
  output logic             s_wready_o,
  input  wire logic [31:0] s_wdata_i,
  input  wire logic [3:0]  s_wstrb_i,
  output logic             s_bvalid_o,
  input  wire logic        s_bready_i,
  output logic [1:0]       s_bresp_o,
  input  wire logic        s_arvalid_i,
  output logic             s_arready_o,
  input  wire logic [7:0]  s_araddr_i,
  output logic             s_rvalid_o,
  input  wire logic        s_rready_i,
  output logic [31:0]      s_rdata_o,
  output logic [1:0]       s_rresp_o,
  // device side, AXI4-Lite master
  output logic             m_awvalid_o,
  input  wire logic        m_awready_i,
  output logic [31:0]      m_awaddr_o,
  output logic             m_wvalid_o,
  input  wire logic        m_wready_i,
  output logic [31:0]      m_wdata_o,
  output logic [3:0]       m_wstrb_o,
  input  wire logic        m_bvalid_i,
  output logic             m_bready_o,
  input  wire logic [1:0]  m_bresp_i,
  output logic             m_arvalid_o,
  input  wire logic        m_arready_i,
  output logic [31:0]      m_araddr_o,
  input  wire logic        m_rvalid_i,
  output logic             m_rready_o,
  input  wire logic [31:0] m_rdata_i,
  input  wire logic [1:0]  m_rresp_i
);

  logic [31:0] cfg_q;
  logic [31:0] setup_lo_q;
  logic [31:0] setup_hi_q;
  logic [31:0] txdata_q;
  logic [31:0] rxdata_q;
  logic [6:0]  status_q;
  logic        cmd_go_q;
  hc_op_e      cmd_op_q;
  hc_op_e      op_q;
  hc_seq_e     seq_q;
  logic        wait_q;
  logic        req_q;
  logic        req_we_q;
  logic [31:0] req_addr_q;
  logic [31:0] req_data_q;
  logic [31:0] csr_last_q;
  logic [31:0] hold_cnt_q;
  logic        seq_we;
  logic [31:0] seq_addr;
  logic [31:0] seq_data;
  logic        bus_done;
  logic        in_phase;
  logic        wr_take;
  logic        rd_take;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---------------- software slave ----------------
  assign wr_take = s_awready_o && s_awvalid_i && s_wvalid_i;
  assign rd_take = s_arready_o && s_arvalid_i;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_awready_o <= 1'b0;
      s_wready_o  <= 1'b0;
      s_bvalid_o  <= 1'b0;
      s_bresp_o   <= `HC_RESP_OKAY;
    end else begin
      s_awready_o <= s_awvalid_i && s_wvalid_i && !s_awready_o && !s_bvalid_o;
      s_wready_o  <= s_awvalid_i && s_wvalid_i && !s_awready_o && !s_bvalid_o;
      if (wr_take) begin
        s_bvalid_o <= 1'b1;
        s_bresp_o  <= (s_awaddr_i > `HC_REG_RXDATA || s_awaddr_i[1:0] != 2'b00)
                      ? `HC_RESP_SLVERR : `HC_RESP_OKAY;
      end else if (s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_q      <= 32'h0000_0000;
      setup_lo_q <= 32'h0000_0000;
      setup_hi_q <= 32'h0000_0000;
      txdata_q   <= 32'h0000_0000;
      cmd_go_q   <= 1'b0;
      cmd_op_q   <= HC_OP_NONE;
    end else begin
      cmd_go_q <= 1'b0;
      if (wr_take) begin
        case (s_awaddr_i)
          `HC_REG_CMD: begin
            if (s_wstrb_i[0] && seq_q == SQ_IDLE) begin
              cmd_go_q <= 1'b1;
              cmd_op_q <= hc_op_e'(s_wdata_i[3:0]);
            end
          end
          `HC_REG_CFG:      cfg_q      <= merge(cfg_q, s_wdata_i, s_wstrb_i);
          `HC_REG_SETUP_LO: setup_lo_q <= merge(setup_lo_q, s_wdata_i, s_wstrb_i);
          `HC_REG_SETUP_HI: setup_hi_q <= merge(setup_hi_q, s_wdata_i, s_wstrb_i);
          `HC_REG_TXDATA:   txdata_q   <= merge(txdata_q, s_wdata_i, s_wstrb_i);
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_arready_o <= 1'b0;
      s_rvalid_o  <= 1'b0;
      s_rdata_o   <= 32'h0000_0000;
      s_rresp_o   <= `HC_RESP_OKAY;
    end else begin
      s_arready_o <= s_arvalid_i && !s_arready_o && !s_rvalid_o;
      if (rd_take) begin
        s_rvalid_o <= 1'b1;
        s_rresp_o  <= `HC_RESP_OKAY;
        case (s_araddr_i)
          `HC_REG_CMD:      s_rdata_o <= {28'h000_0000, op_q};
          `HC_REG_CFG:      s_rdata_o <= cfg_q;
          `HC_REG_STATUS:   s_rdata_o <= {25'h000_0000, status_q};
          `HC_REG_SETUP_LO: s_rdata_o <= setup_lo_q;
          `HC_REG_SETUP_HI: s_rdata_o <= setup_hi_q;
          `HC_REG_TXDATA:   s_rdata_o <= txdata_q;
          `HC_REG_RXDATA:   s_rdata_o <= rxdata_q;
          default: begin
            s_rdata_o <= 32'h0000_0000;
            s_rresp_o <= `HC_RESP_SLVERR;
          end
        endcase
      end else if (s_rready_i) begin
        s_rvalid_o <= 1'b0;
      end
    end
  end

  // ---------------- device master ----------------
  assign bus_done = (m_bready_o && m_bvalid_i) || (m_rready_o && m_rvalid_i);

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      m_awvalid_o <= 1'b0;
      m_awaddr_o  <= 32'h0000_0000;
      m_wvalid_o  <= 1'b0;
      m_wdata_o   <= 32'h0000_0000;
      m_wstrb_o   <= 4'h0;
      m_bready_o  <= 1'b0;
      m_arvalid_o <= 1'b0;
      m_araddr_o  <= 32'h0000_0000;
      m_rready_o  <= 1'b0;
    end else begin
      if (req_q && req_we_q) begin
        m_awvalid_o <= 1'b1;
        m_awaddr_o  <= req_addr_q;
        m_wvalid_o  <= 1'b1;
        m_wdata_o   <= req_data_q;
        m_wstrb_o   <= 4'hF;
        m_bready_o  <= 1'b1;
      end else begin
        if (m_awready_i) m_awvalid_o <= 1'b0;
        if (m_wready_i)  m_wvalid_o  <= 1'b0;
        if (m_bvalid_i)  m_bready_o  <= 1'b0;
      end
      if (req_q && !req_we_q) begin
        m_arvalid_o <= 1'b1;
        m_araddr_o  <= req_addr_q;
        m_rready_o  <= 1'b1;
      end else begin
        if (m_arready_i) m_arvalid_o <= 1'b0;
        if (m_rvalid_i)  m_rready_o  <= 1'b0;
      end
    end
  end

  // ---------------- phase sequencer ----------------
  assign in_phase = (op_q == HC_OP_IN_DATA) || (op_q == HC_OP_IN_STATUS);

  always_comb begin
    seq_we   = 1'b1;
    seq_addr = `HC_DEV_CSR0;
    seq_data = 32'h0000_0000;
    case (seq_q)
      SQ_PWR_SET: begin
        seq_addr = `HC_DEV_POWER;
        seq_data[`HC_PWR_HS_EN] = cfg_q[`HC_CFG_HS_EN];
        seq_data[`HC_PWR_PD_EN] = cfg_q[`HC_CFG_PD_EN];
        seq_data[`HC_PWR_SUSPEND] = (op_q == HC_OP_SUSPEND);
        seq_data[`HC_PWR_RESUME] = (op_q == HC_OP_RESUME);
        seq_data[`HC_PWR_RESET] = (op_q == HC_OP_BUS_RESET);
      end
      SQ_PWR_CLR: begin
        seq_addr = `HC_DEV_POWER;
        seq_data[`HC_PWR_HS_EN] = cfg_q[`HC_CFG_HS_EN];
        seq_data[`HC_PWR_PD_EN] = cfg_q[`HC_CFG_PD_EN];
      end
      SQ_PWR_READ: begin
        seq_we   = 1'b0;
        seq_addr = `HC_DEV_POWER;
      end
      SQ_FIFO_A: begin
        seq_addr = `HC_DEV_FIFO0;
        seq_data = (op_q == HC_OP_SETUP) ? setup_lo_q : txdata_q;
      end
      SQ_FIFO_B: begin
        seq_addr = `HC_DEV_FIFO0;
        seq_data = setup_hi_q;
      end
      SQ_CSR_GO: begin
        case (op_q)
          HC_OP_SETUP: begin
            seq_data[`HC_CSR_SETUP] = 1'b1;
            seq_data[`HC_CSR_TXRDY] = 1'b1;
          end
          HC_OP_IN_DATA:  seq_data[`HC_CSR_INREQ] = 1'b1;
          HC_OP_OUT_DATA: seq_data[`HC_CSR_TXRDY] = 1'b1;
          HC_OP_IN_STATUS: begin
            seq_data[`HC_CSR_STATUS] = 1'b1;
            seq_data[`HC_CSR_INREQ] = 1'b1;
          end
          HC_OP_OUT_STATUS: begin
            seq_data[`HC_CSR_STATUS] = 1'b1;
            seq_data[`HC_CSR_TXRDY] = 1'b1;
          end
          default: ;
        endcase
      end
      SQ_POLL: seq_we = 1'b0;
      SQ_RXREAD: begin
        seq_we   = 1'b0;
        seq_addr = `HC_DEV_FIFO0;
      end
      SQ_NAKFIX: begin
        seq_data[`HC_CSR_NAKTO] = 1'b1;
        seq_data[`HC_CSR_FLUSH] = !in_phase;
      end
      SQ_NAKCLR: begin
        if (!cfg_q[`HC_CFG_ABORT]) begin
          seq_data = csr_last_q;
          seq_data[`HC_CSR_NAKTO] = 1'b0;
        end
      end
      SQ_LIMIT: begin
        seq_addr = `HC_DEV_NAKLIMIT0;
        seq_data = {24'h00_0000, cfg_q[`HC_CFG_LIM_HI:`HC_CFG_LIM_LO]};
      end
      default: seq_we = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      seq_q      <= SQ_IDLE;
      op_q       <= HC_OP_NONE;
      wait_q     <= 1'b0;
      req_q      <= 1'b0;
      req_we_q   <= 1'b0;
      req_addr_q <= 32'h0000_0000;
      req_data_q <= 32'h0000_0000;
      csr_last_q <= 32'h0000_0000;
      hold_cnt_q <= 32'h0000_0000;
      rxdata_q   <= 32'h0000_0000;
      status_q   <= 7'h00;
    end else begin
      req_q <= 1'b0;
      if (seq_q != SQ_IDLE && seq_q != SQ_HOLD && !wait_q) begin
        req_q      <= 1'b1;
        req_we_q   <= seq_we;
        req_addr_q <= seq_addr;
        req_data_q <= seq_data;
        wait_q     <= 1'b1;
      end
      if (bus_done) wait_q <= 1'b0;
      case (seq_q)
        SQ_IDLE: begin
          // codes above the last defined op are ignored like op 0
          if (cmd_go_q && cmd_op_q != HC_OP_NONE && cmd_op_q <= HC_OP_NAK_LIMIT) begin
            op_q <= cmd_op_q;
            status_q[`HC_ST_BUSY] <= 1'b1;
            status_q[`HC_ST_DONE] <= 1'b0;
            status_q[`HC_ST_STALL] <= 1'b0;
            status_q[`HC_ST_ERROR] <= 1'b0;
            status_q[`HC_ST_NAKTO] <= 1'b0;
            case (cmd_op_q)
              HC_OP_SUSPEND, HC_OP_RESUME, HC_OP_BUS_RESET: seq_q <= SQ_PWR_SET;
              HC_OP_SETUP, HC_OP_OUT_DATA: seq_q <= SQ_FIFO_A;
              HC_OP_NAK_LIMIT: seq_q <= SQ_LIMIT;
              default: seq_q <= SQ_CSR_GO;
            endcase
          end
        end
        SQ_PWR_SET: if (bus_done) begin
          hold_cnt_q <= 32'h0000_0000;
          status_q[`HC_ST_SUSP] <= (op_q == HC_OP_SUSPEND);
          seq_q <= (op_q == HC_OP_SUSPEND) ? SQ_IDLE : SQ_HOLD;
          if (op_q == HC_OP_SUSPEND) begin
            status_q[`HC_ST_BUSY] <= 1'b0;
            status_q[`HC_ST_DONE] <= 1'b1;
          end
        end
        SQ_HOLD: begin
          hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
          if (hold_cnt_q == 32'(HOLD_CYCLES - 1)) seq_q <= SQ_PWR_CLR;
        end
        SQ_PWR_CLR: if (bus_done) begin
          seq_q <= (op_q == HC_OP_BUS_RESET) ? SQ_PWR_READ : SQ_IDLE;
          if (op_q != HC_OP_BUS_RESET) begin
            status_q[`HC_ST_BUSY] <= 1'b0;
            status_q[`HC_ST_DONE] <= 1'b1;
          end
        end
        SQ_PWR_READ: if (bus_done) begin
          status_q[`HC_ST_HS] <= m_rdata_i[`HC_PWR_HS_ACTIVE];
          status_q[`HC_ST_BUSY] <= 1'b0;
          status_q[`HC_ST_DONE] <= 1'b1;
          seq_q <= SQ_IDLE;
        end
        SQ_FIFO_A: if (bus_done) seq_q <= (op_q == HC_OP_SETUP) ? SQ_FIFO_B : SQ_CSR_GO;
        SQ_FIFO_B: if (bus_done) seq_q <= SQ_CSR_GO;
        SQ_CSR_GO: if (bus_done) seq_q <= SQ_POLL;
        SQ_POLL: if (bus_done) begin
          csr_last_q <= m_rdata_i;
          if (m_rdata_i[`HC_CSR_STALL] || m_rdata_i[`HC_CSR_ERROR]) begin
            status_q[`HC_ST_STALL] <= m_rdata_i[`HC_CSR_STALL];
            status_q[`HC_ST_ERROR] <= m_rdata_i[`HC_CSR_ERROR];
            seq_q <= SQ_RXCLR;
          end else if (m_rdata_i[`HC_CSR_NAKTO]) begin
            status_q[`HC_ST_NAKTO] <= 1'b1;
            seq_q <= cfg_q[`HC_CFG_ABORT] ? SQ_NAKFIX : SQ_NAKCLR;
          end else if (in_phase && m_rdata_i[`HC_CSR_RXRDY]) begin
            seq_q <= (op_q == HC_OP_IN_DATA) ? SQ_RXREAD : SQ_RXCLR;
          end else if (!in_phase && !m_rdata_i[`HC_CSR_TXRDY]) begin
            status_q[`HC_ST_BUSY] <= 1'b0;
            status_q[`HC_ST_DONE] <= 1'b1;
            seq_q <= SQ_IDLE;
          end
        end
        SQ_RXREAD: if (bus_done) begin
          rxdata_q <= m_rdata_i;
          seq_q <= SQ_RXCLR;
        end
        SQ_NAKFIX: if (bus_done) seq_q <= SQ_NAKCLR;
        SQ_RXCLR, SQ_NAKCLR, SQ_LIMIT: if (bus_done) begin
          if (seq_q == SQ_NAKCLR && !cfg_q[`HC_CFG_ABORT]) begin
            status_q[`HC_ST_NAKTO] <= 1'b0;
            seq_q <= SQ_POLL;
          end else begin
            status_q[`HC_ST_BUSY] <= 1'b0;
            status_q[`HC_ST_DONE] <= 1'b1;
            seq_q <= SQ_IDLE;
          end
        end
        default: seq_q <= SQ_IDLE;
      endcase
    end
  end

  // ---------------- checks ----------------
  logic [1:0] fifo_wr_q;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) fifo_wr_q <= 2'd0;
    else if (seq_q == SQ_IDLE) fifo_wr_q <= 2'd0;
    else if (bus_done && (seq_q == SQ_FIFO_A || seq_q == SQ_FIFO_B)) fifo_wr_q <= fifo_wr_q + 2'd1;
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  hold_length_a: assert property (seq_q == SQ_HOLD && seq_q != $past(seq_q) |->
      hold_cnt_q == 32'h0000_0000)
    else $error("hold counter not restarted");
  hold_exit_a: assert property ($past(seq_q) == SQ_HOLD && seq_q == SQ_PWR_CLR |->
      $past(hold_cnt_q) == 32'(HOLD_CYCLES - 1))
    else $error("power bit released before hold time");
  setup_loaded_a: assert property (seq_q == SQ_CSR_GO && op_q == HC_OP_SETUP |->
      fifo_wr_q == 2'd2)
    else $error("setup issued without eight bytes loaded");
  setup_together_a: assert property (m_awvalid_o && m_awaddr_o == `HC_DEV_CSR0 &&
      op_q == HC_OP_SETUP && $past(seq_q) == SQ_CSR_GO |->
      m_wdata_o[`HC_CSR_SETUP] && m_wdata_o[`HC_CSR_TXRDY])
    else $error("setup and transmit-ready not set together");
  status_quiet_a: assert property (op_q == HC_OP_IN_STATUS |->
      !(m_arvalid_o && m_araddr_o == `HC_DEV_FIFO0))
    else $error("fifo read during in status");
  out_status_a: assert property (seq_q == SQ_CSR_GO && op_q == HC_OP_OUT_STATUS &&
      m_awvalid_o |->
      m_wdata_o[`HC_CSR_STATUS] && m_wdata_o[`HC_CSR_TXRDY] && !m_wdata_o[`HC_CSR_INREQ])
    else $error("out status bits wrong");
  abort_drop_a: assert property (seq_q == SQ_NAKFIX && in_phase && m_awvalid_o |->
      !m_wdata_o[`HC_CSR_INREQ] && !m_wdata_o[`HC_CSR_STATUS] && m_wdata_o[`HC_CSR_NAKTO])
    else $error("abort keeps request bits");
  rx_order_a: assert property ($past(seq_q) == SQ_RXREAD && bus_done && seq_q == SQ_RXREAD |=>
      seq_q == SQ_RXCLR && rxdata_q == $past(m_rdata_i))
    else $error("receive data not taken before clear");
  aw_hold_a: assert property (m_awvalid_o && !m_awready_i |=>
      m_awvalid_o && $stable(m_awaddr_o) && $stable(m_wdata_o))
    else $error("write address dropped before taken");

  setup_seen_c: cover property (seq_q == SQ_POLL && op_q == HC_OP_SETUP ##1 seq_q == SQ_IDLE);
  nak_retry_c:  cover property (seq_q == SQ_NAKCLR ##[1:20] seq_q == SQ_POLL);
  reset_done_c: cover property (seq_q == SQ_PWR_READ ##[1:20] seq_q == SQ_IDLE);

endmodule

// ==== hc_dev_model.sv ====
`timescale 1ns/1ps

module hc_dev_model #(
  parameter logic [31:0] RX_WORD = 32'h5A5A_0F0F
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic        hs_i,
  input  wire logic        awv_i,
  output logic             awr_o,
  input  wire logic [31:0] aw_i,
  input  wire logic        wv_i,
  output logic             wr_o,
  input  wire logic [31:0] wd_i,
  output logic             bv_o,
  input  wire logic        br_i,
  input  wire logic        arv_i,
  output logic             arr_o,
  input  wire logic [31:0] ar_i,
  output logic             rv_o,
  input  wire logic        rr_i,
  output logic [31:0]      rd_o
);
  logic [31:0] pwr_q, fifo_q [2];
  logic [8:0]  csr_q;
  logic [7:0]  lim_q, go_q;
  logic [1:0]  cnt_q;
  logic        idx_q, nak_q, rst_seen_q, res_seen_q, hs_q, flush_q;
  int          starts_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {awr_o, wr_o, bv_o, arr_o, rv_o, idx_q, nak_q, cnt_q} <= '0;
      {rst_seen_q, res_seen_q, hs_q, flush_q} <= '0;
      {pwr_q, csr_q, lim_q, go_q, rd_o} <= '0;
      starts_q <= 0;
    end else begin
      awr_o <= awv_i && wv_i && !bv_o && !awr_o;
      wr_o  <= awv_i && wv_i && !bv_o && !awr_o;
      arr_o <= arv_i && !rv_o && !arr_o;
      if (bv_o && br_i) bv_o <= 1'b0;
      // released read data does not keep its last value
      if (rv_o && rr_i) begin
        rv_o <= 1'b0;
        rd_o <= ~rd_o;
      end
      if (mode_i != 2'd3) nak_q <= 1'b0;
      if (cnt_q != 2'd0) cnt_q <= cnt_q - 2'd1;
      if (cnt_q == 2'd1) begin
        if (mode_i == 2'd1) csr_q <= 9'h004;
        else if (mode_i == 2'd2) csr_q <= 9'h010;
        else if (mode_i == 2'd3 && !nak_q) begin
          csr_q[7] <= 1'b1;
          nak_q    <= 1'b1;
        end else csr_q <= {8'h00, csr_q[5]};
      end
      if (arr_o) begin
        rv_o <= 1'b1;
        case (ar_i[7:0])
          8'h00:   rd_o <= {pwr_q[31:5], hs_q, pwr_q[3:0]};
          8'h04:   rd_o <= {23'h0, csr_q};
          8'h08:   rd_o <= {24'h0, lim_q};
          default: rd_o <= RX_WORD;
        endcase
      end
      if (awr_o) begin
        bv_o <= 1'b1;
        case (aw_i[7:0])
          8'h00: begin
            pwr_q <= wd_i;
            if (wd_i[3]) rst_seen_q <= 1'b1;
            if (wd_i[3]) hs_q <= wd_i[5] & hs_i;
            if (wd_i[2]) res_seen_q <= 1'b1;
          end
          8'h04: begin
            csr_q <= {1'b0, wd_i[7:0]};
            if (wd_i[8]) flush_q <= 1'b1;
            if ((wd_i[1] || wd_i[5]) && !wd_i[7]) begin
              cnt_q    <= 2'd3;
              go_q     <= wd_i[7:0];
              starts_q <= starts_q + 1;
              idx_q    <= 1'b0;
            end
          end
          8'h08: lim_q <= wd_i[7:0];
          default: begin
            fifo_q[idx_q] <= wd_i;
            idx_q         <= ~idx_q;
          end
        endcase
      end
    end
  end
endmodule

// ==== hc_usb_host_tb.sv ====
`timescale 1ns/1ps
`include "hc_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end

module hc_usb_host_tb;
  logic        ref_clk, reset, sawv, swv, sbr, sarv, srr, hs;
  logic [7:0]  saw, sar;
  logic [31:0] swd, rdv;
  logic [1:0]  mode, rsp;
  logic [3:0]  sws;
  wire         sawr, swr, sbv, sarr, srv, mawv, mawr, mwv, mwr, mbv, mbr, marv, marr, mrv, mrr;
  wire  [1:0]  sbrsp, srrsp;
  wire  [31:0] srd, maw, mwd, mar, mrd;
  int          errors, n_tests, s0;

  hc_usb_host #(.HOLD_CYCLES(8)) DUT (
    .ref_clk_i(ref_clk), .reset_i(reset), .s_awvalid_i(sawv), .s_awready_o(sawr),
    .s_awaddr_i(saw), .s_wvalid_i(swv), .s_wready_o(swr), .s_wdata_i(swd),
    .s_wstrb_i(sws), .s_bvalid_o(sbv), .s_bready_i(sbr), .s_bresp_o(sbrsp),
    .s_arvalid_i(sarv), .s_arready_o(sarr), .s_araddr_i(sar), .s_rvalid_o(srv),
    .s_rready_i(srr), .s_rdata_o(srd), .s_rresp_o(srrsp), .m_awvalid_o(mawv),
    .m_awready_i(mawr), .m_awaddr_o(maw), .m_wvalid_o(mwv), .m_wready_i(mwr),
    .m_wdata_o(mwd), .m_wstrb_o(), .m_bvalid_i(mbv), .m_bready_o(mbr),
    .m_bresp_i(2'b00), .m_arvalid_o(marv), .m_arready_i(marr), .m_araddr_o(mar),
    .m_rvalid_i(mrv), .m_rready_o(mrr), .m_rdata_i(mrd), .m_rresp_i(2'b00));

  hc_dev_model #(.RX_WORD(32'hC0DE_0042)) PART (
    .clk_i(ref_clk), .rst_i(reset), .mode_i(mode), .hs_i(hs), .awv_i(mawv),
    .awr_o(mawr), .aw_i(maw), .wv_i(mwv), .wr_o(mwr), .wd_i(mwd), .bv_o(mbv),
    .br_i(mbr), .arv_i(marv), .arr_o(marr), .ar_i(mar), .rv_o(mrv), .rr_i(mrr),
    .rd_o(mrd));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    saw  <= a;
    swd  <= d;
    sawv <= 1'b1;
    swv  <= 1'b1;
    sbr  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (sawr) sawv <= 1'b0;
      if (swr) swv <= 1'b0;
    end while (!sbv);
    sbr <= 1'b0;
    `CHK(sbrsp, r)
    // one idle edge so a following call never re-drives bready in this step
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    sar  <= a;
    sarv <= 1'b1;
    srr  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (sarr) sarv <= 1'b0;
    end while (!srv);
    srr <= 1'b0;
    d = srd;
    r = srrsp;
    @(posedge ref_clk);
  endtask

  // status bits 5:1 are suspended, high speed, nak timeout, error, stall
  task automatic run(input logic [3:0] op, input logic [4:0] e, input logic [4:0] m = 5'h1F);
    wr(`HC_REG_CMD, {28'h0, op}, `HC_RESP_OKAY);
    do rd(`HC_REG_STATUS, rdv, rsp);
    while (rdv[`HC_ST_BUSY] || !rdv[`HC_ST_DONE]);
    `CHK(rdv[5:1] & m, e)
  endtask

  task automatic t_regs;
    rd(`HC_REG_STATUS, rdv, rsp);
    `CHK(rdv, 32'h0000_0000)
    rd(8'h40, rdv, rsp);
    `CHK(rsp, `HC_RESP_SLVERR)
    wr(8'h44, 32'h0000_0001, `HC_RESP_SLVERR);
    wr(`HC_REG_CFG, 32'h0000_D701, `HC_RESP_OKAY);
    rd(`HC_REG_CFG, rdv, rsp);
    `CHK(rdv, 32'h0000_D701)
    run(4'd9, 5'b00000);
    `CHK(PART.lim_q, 8'hD7)
    sws <= 4'h2;
    wr(`HC_REG_CFG, 32'h0000_3355, `HC_RESP_OKAY);
    sws <= 4'hF;
    rd(`HC_REG_CFG, rdv, rsp);
    `CHK(rdv, 32'h0000_3301)
  endtask

  task automatic t_power;
    wr(`HC_REG_CFG, 32'h0000_D703, `HC_RESP_OKAY);
    run(4'd3, 5'b01000);
    `CHK(PART.rst_seen_q, 1'b1)
    `CHK(PART.pwr_q[3], 1'b0)
    run(4'd1, 5'b11000);
    `CHK(PART.pwr_q[1:0], 2'b11)
    run(4'd2, 5'b01000);
    `CHK(PART.res_seen_q, 1'b1)
    `CHK(PART.pwr_q[2:1], 2'b00)
  endtask

  task automatic t_read_req;
    wr(`HC_REG_SETUP_LO, 32'h0100_0680, `HC_RESP_OKAY);
    wr(`HC_REG_SETUP_HI, 32'h0040_0000, `HC_RESP_OKAY);
    run(4'd4, 5'b01000);
    `CHK(PART.go_q, 8'h0A)
    `CHK({PART.fifo_q[1], PART.fifo_q[0]}, 64'h0040_0000_0100_0680)
    run(4'd5, 5'b01000);
    `CHK(PART.go_q, 8'h20)
    rd(`HC_REG_RXDATA, rdv, rsp);
    `CHK(rdv, 32'hC0DE_0042)
    `CHK(PART.csr_q, 9'h000)
    run(4'd8, 5'b01000);
    `CHK(PART.go_q, 8'h42)
  endtask

  task automatic t_write_req;
    wr(`HC_REG_TXDATA, 32'hA5A5_1234, `HC_RESP_OKAY);
    run(4'd6, 5'b01000);
    `CHK(PART.go_q, 8'h02)
    `CHK(PART.fifo_q[0], 32'hA5A5_1234)
    run(4'd7, 5'b01000);
    `CHK(PART.go_q, 8'h60)
    `CHK(PART.csr_q, 9'h000)
  endtask

  task automatic t_fail;
    mode <= 2'd1;
    run(4'd5, 5'b01001);
    mode <= 2'd2;
    run(4'd6, 5'b01010);
    mode <= 2'd3;
    s0 = PART.starts_q;
    run(4'd5, 5'b01000, 5'b11011);
    `CHK(PART.starts_q - s0, 2)
    mode <= 2'd0;
    wr(`HC_REG_CFG, 32'h0000_D707, `HC_RESP_OKAY);
    mode <= 2'd3;
    run(4'd6, 5'b01100);
    `CHK(PART.flush_q, 1'b1)
    mode <= 2'd0;
    @(posedge ref_clk);
    mode <= 2'd3;
    run(4'd7, 5'b01100);
    `CHK(PART.csr_q, 9'h000)
    mode <= 2'd0;
  endtask

  task automatic wrap_up;
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    {reset, sawv, swv, sbr, sarv, srr} = 6'h20;
    {saw, sar, swd, mode, hs} = '0;
    sws     = 4'hF;
    errors  = 0;
    n_tests = 0;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    hs    <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_power();
    t_read_req();
    t_write_req();
    t_fail();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    wrap_up();
  end
endmodule
